// file: common/ebtmc_pkg.sv
// Constants, field layouts and carrier types for the 8-bit timer channel pair
package ebtmc_pkg;

  // Word index of each paired register on the internal 16-bit bus
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h1;
  localparam logic [2:0] ADDR_CONST_A = 3'h2;
  localparam logic [2:0] ADDR_CONST_B = 3'h3;
  localparam logic [2:0] ADDR_COUNT = 3'h4;

  // Channel slots: even channel on the upper byte, odd channel on the lower byte
  localparam int CH_EVEN = 0;
  localparam int CH_ODD = 1;
  localparam int NUM_CH = 2;

  // Control/status field positions
  localparam int BIT_MATCH_B = 7;
  localparam int BIT_MATCH_A = 6;
  localparam int BIT_WRAP = 5;
  localparam int BIT_CAPTURE_SEL = 4;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CONST = 8'hff;
  localparam logic EVEN_BIT4_VALUE = 1'b1;

  // Clock source codes
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_DIV8 = 3'h1;
  localparam logic [2:0] CKS_DIV64 = 3'h2;
  localparam logic [2:0] CKS_DIV8192 = 3'h3;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

  // Prescaler taps: divide by 8, 64 and 8192
  localparam int PRE_W = 13;
  localparam logic [PRE_W-1:0] PRE_MASK8 = 13'h0007;
  localparam logic [PRE_W-1:0] PRE_MASK64 = 13'h003f;
  localparam logic [PRE_W-1:0] PRE_MASK8192 = 13'h1fff;

  // Counter clear codes
  localparam logic [1:0] CLR_ON_A = 2'h1;
  localparam logic [1:0] CLR_ON_B = 2'h2;

  // Output actions, ordered so that a larger code has higher priority
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_ZERO = 2'h1;
  localparam logic [1:0] ACT_ONE = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Capture edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // Control register layout
  typedef struct packed {
    logic irq_en_b;
    logic irq_en_a;
    logic wrap_irq_en;
    logic clear_source_sel_hi;
    logic clear_source_sel_lo;
    logic [2:0] clock_source_sel;
  } ebtmc_ctl_t;

  // CPU request on the internal 16-bit bus
  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic be_hi;
    logic be_lo;
    logic [15:0] wdata;
  } ebtmc_bus_req_t;

endpackage

// file: logic/ebtmc_timer_pair.sv
// Even/odd 8-bit timer channel pair with compare outputs and odd-channel capture
`timescale 1ns/1ps

module ebtmc_timer_pair (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire ebtmc_pkg::ebtmc_bus_req_t bus_req_i,
  output logic [15:0] bus_rdata_o,
  input wire logic ext_clk_i,
  output logic timer_out_pin_o,
  output logic timer_out_pin_oe_n_o,
  input wire logic timer_io_pin_i,
  output logic timer_io_pin_o,
  output logic timer_io_pin_oe_n_o,
  output logic even_match_a_irq_o,
  output logic even_match_b_irq_o,
  output logic odd_match_a_irq_o,
  output logic odd_match_b_irq_o
);
  import ebtmc_pkg::*;

  // Edge seen on a synchronised signal for a two-bit edge code
  function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
                                    input logic fall);
    case (mode)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Byte lane of a channel: even on the upper byte, odd on the lower
  function automatic logic lane_en(input ebtmc_bus_req_t req, input int ch);
    lane_en = (ch == CH_EVEN) ? req.be_hi : req.be_lo;
  endfunction

  function automatic logic [7:0] lane_data(input ebtmc_bus_req_t req, input int ch);
    lane_data = (ch == CH_EVEN) ? req.wdata[15:8] : req.wdata[7:0];
  endfunction

  // Register write strobe for one channel's byte of a given word
  function automatic logic reg_wr(input ebtmc_bus_req_t req, input logic [2:0] addr,
                                  input int ch);
    reg_wr = req.wr & (req.addr == addr) & lane_en(req, ch);
  endfunction

  // Registers of both channels, indexed by channel slot
  logic [7:0] count_value [NUM_CH];
  logic [7:0] const_a_reg [NUM_CH];
  logic [7:0] const_b_capture_reg [NUM_CH];
  ebtmc_ctl_t timer_control [NUM_CH];
  logic [NUM_CH-1:0] match_b_flag;
  logic [NUM_CH-1:0] match_a_flag;
  logic [NUM_CH-1:0] wrap_flag;
  logic [NUM_CH-1:0] flag_b_armed;
  logic [NUM_CH-1:0] flag_a_armed;
  logic [NUM_CH-1:0] flag_w_armed;
  logic capture_select;
  logic odd_bit4_spare;
  logic [1:0] out_b_sel [NUM_CH];
  logic [1:0] out_a_sel [NUM_CH];

  logic [PRE_W-1:0] prescale;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic cap_sync1;
  logic cap_sync2;
  logic cap_prev;

  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0] match_a;
  logic [NUM_CH-1:0] match_b;
  logic [NUM_CH-1:0] clear_cnt;
  logic [NUM_CH-1:0] wrap;
  logic [NUM_CH-1:0] out_enable;
  logic [1:0] out_action [NUM_CH];
  logic capture_ev;
  logic ext_rise;
  logic ext_fall;
  logic tap8;
  logic tap64;
  logic tap8192;
  logic [15:0] next_rdata;

  // Free-running prescaler shared by both channels
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // One-cycle enables at the divided rates
  assign tap8 = (prescale & PRE_MASK8) == PRE_MASK8;
  assign tap64 = (prescale & PRE_MASK64) == PRE_MASK64;
  assign tap8192 = (prescale & PRE_MASK8192) == PRE_MASK8192;

  // Two-stage synchronisers; edge detection looks only at the second stage
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      cap_sync1 <= 1'b0;
      cap_sync2 <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      ext_sync1 <= ext_clk_i;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
      cap_sync1 <= timer_io_pin_i;
      cap_sync2 <= cap_sync1;
      cap_prev <= cap_sync2;
    end
  end

  // Short pulses on either input are lost by the sampling, as the source is warned
  assign ext_rise = ext_sync2 & ~ext_prev;
  assign ext_fall = ~ext_sync2 & ext_prev;

  // Capture event on the odd channel pin, edge chosen by the B field
  assign capture_ev = capture_select
    & edge_hit(out_b_sel[CH_ODD], cap_sync2 & ~cap_prev, ~cap_sync2 & cap_prev);

  // Per-channel count pulses, matches, clears and output actions
  always_comb begin
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] clr;
    act_a = ACT_NONE;
    act_b = ACT_NONE;
    clr = 2'h0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      case (timer_control[ch].clock_source_sel)
        CKS_DIV8: tick[ch] = tap8;
        CKS_DIV64: tick[ch] = tap64;
        CKS_DIV8192: tick[ch] = tap8192;
        CKS_EXT_RISE: tick[ch] = ext_rise;
        CKS_EXT_FALL: tick[ch] = ext_fall;
        CKS_EXT_BOTH: tick[ch] = ext_rise | ext_fall;
        default: tick[ch] = 1'b0;
      endcase
      // Match only when the pulse moves the counter off the equal value
      match_a[ch] = tick[ch] & (count_value[ch] == const_a_reg[ch]);
      // Capture mode removes register B compare from both channels
      match_b[ch] = tick[ch] & (count_value[ch] == const_b_capture_reg[ch])
                    & ~capture_select;
      clr = {timer_control[ch].clear_source_sel_hi, timer_control[ch].clear_source_sel_lo};
      clear_cnt[ch] = ((clr == CLR_ON_A) & match_a[ch])
                    | ((clr == CLR_ON_B) & match_b[ch])
                    | ((clr == CLR_ON_B) & (ch == CH_ODD) & capture_ev);
      wrap[ch] = tick[ch] & (count_value[ch] == COUNT_TOP) & ~clear_cnt[ch];
      act_a = match_a[ch] ? out_a_sel[ch] : ACT_NONE;
      act_b = match_b[ch] ? out_b_sel[ch] : ACT_NONE;
      // Codes ordered by priority, so the larger request wins
      out_action[ch] = (act_a > act_b) ? act_a : act_b;
      out_enable[ch] = (out_a_sel[ch] != 2'h0) | (out_b_sel[ch] != 2'h0);
    end
    // Odd pin is a dedicated input while capturing; the even pin is released too
    out_enable[CH_ODD] = out_enable[CH_ODD] & ~capture_select;
    out_enable[CH_EVEN] = out_enable[CH_EVEN] & ~capture_select;
  end

  // Counters: CPU write first, then clear, then increment
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        count_value[ch] <= RST_BYTE;
      end
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (reg_wr(bus_req_i, ADDR_COUNT, ch)) begin
          count_value[ch] <= lane_data(bus_req_i, ch);
        end else if (clear_cnt[ch]) begin
          count_value[ch] <= COUNT_ZERO;
        end else if (tick[ch]) begin
          count_value[ch] <= count_value[ch] + 8'h01;
        end
      end
    end
  end

  // Constant registers; a capture wins over a CPU write in the same cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        const_a_reg[ch] <= RST_CONST;
        const_b_capture_reg[ch] <= RST_CONST;
      end
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (reg_wr(bus_req_i, ADDR_CONST_A, ch)) begin
          const_a_reg[ch] <= lane_data(bus_req_i, ch);
        end
        if ((ch == CH_ODD) && capture_ev) begin
          const_b_capture_reg[ch] <= count_value[ch];
        end else if (reg_wr(bus_req_i, ADDR_CONST_B, ch)) begin
          const_b_capture_reg[ch] <= lane_data(bus_req_i, ch);
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        timer_control[ch] <= ebtmc_ctl_t'(RST_BYTE);
      end
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (reg_wr(bus_req_i, ADDR_CONTROL, ch)) begin
          timer_control[ch] <= ebtmc_ctl_t'(lane_data(bus_req_i, ch));
        end
      end
    end
  end

  // Writable control/status fields; even bit 4 is fixed and not stored
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_select <= 1'b0;
      odd_bit4_spare <= 1'b0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
        out_b_sel[ch] <= 2'h0;
        out_a_sel[ch] <= 2'h0;
      end
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (reg_wr(bus_req_i, ADDR_CONTROL_STATUS, ch)) begin
          out_b_sel[ch] <= 2'(lane_data(bus_req_i, ch) >> 2);
          out_a_sel[ch] <= 2'(lane_data(bus_req_i, ch));
        end
      end
      if (reg_wr(bus_req_i, ADDR_CONTROL_STATUS, CH_ODD)) begin
        capture_select <= bus_req_i.wdata[BIT_CAPTURE_SEL];
        odd_bit4_spare <= bus_req_i.wdata[BIT_CAPTURE_SEL];
      end
    end
  end

  // Status flags: clear needs a prior read seeing 1; a set in the same cycle wins
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      match_b_flag <= '0;
      match_a_flag <= '0;
      wrap_flag <= '0;
      flag_b_armed <= '0;
      flag_a_armed <= '0;
      flag_w_armed <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        logic wr_cs;
        logic [7:0] wd;
        logic set_b;
        wr_cs = reg_wr(bus_req_i, ADDR_CONTROL_STATUS, ch);
        wd = lane_data(bus_req_i, ch);
        set_b = match_b[ch] | ((ch == CH_ODD) & capture_ev);
        if (set_b) begin
          match_b_flag[ch] <= 1'b1;
        end else if (wr_cs && flag_b_armed[ch] && !wd[BIT_MATCH_B]) begin
          match_b_flag[ch] <= 1'b0;
        end
        if (match_a[ch]) begin
          match_a_flag[ch] <= 1'b1;
        end else if (wr_cs && flag_a_armed[ch] && !wd[BIT_MATCH_A]) begin
          match_a_flag[ch] <= 1'b0;
        end
        if (wrap[ch]) begin
          wrap_flag[ch] <= 1'b1;
        end else if (wr_cs && flag_w_armed[ch] && !wd[BIT_WRAP]) begin
          wrap_flag[ch] <= 1'b0;
        end
        // Arming by a read that sees 1; any write to the byte uses it up
        if (wr_cs) begin
          flag_b_armed[ch] <= 1'b0;
          flag_a_armed[ch] <= 1'b0;
          flag_w_armed[ch] <= 1'b0;
        end else if (bus_req_i.rd && (bus_req_i.addr == ADDR_CONTROL_STATUS)
                     && lane_en(bus_req_i, ch)) begin
          flag_b_armed[ch] <= flag_b_armed[ch] | match_b_flag[ch];
          flag_a_armed[ch] <= flag_a_armed[ch] | match_a_flag[ch];
          flag_w_armed[ch] <= flag_w_armed[ch] | wrap_flag[ch];
        end
      end
    end
  end

  // Pin drivers; level holds when no action is requested
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_out_pin_o <= 1'b0;
      timer_io_pin_o <= 1'b0;
      timer_out_pin_oe_n_o <= 1'b1;
      timer_io_pin_oe_n_o <= 1'b1;
    end else begin
      timer_out_pin_oe_n_o <= ~out_enable[CH_EVEN];
      timer_io_pin_oe_n_o <= ~out_enable[CH_ODD];
      case (out_action[CH_EVEN])
        ACT_ZERO: timer_out_pin_o <= 1'b0;
        ACT_ONE: timer_out_pin_o <= 1'b1;
        ACT_TOGGLE: timer_out_pin_o <= ~timer_out_pin_o;
        default: timer_out_pin_o <= timer_out_pin_o;
      endcase
      case (out_action[CH_ODD])
        ACT_ZERO: timer_io_pin_o <= 1'b0;
        ACT_ONE: timer_io_pin_o <= 1'b1;
        ACT_TOGGLE: timer_io_pin_o <= ~timer_io_pin_o;
        default: timer_io_pin_o <= timer_io_pin_o;
      endcase
    end
  end

  // Read word assembled from both channels; unmapped words read zero
  always_comb begin
    next_rdata = 16'h0000;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      logic [7:0] byte_v;
      byte_v = 8'h00;
      case (bus_req_i.addr)
        ADDR_CONTROL: byte_v = timer_control[ch];
        ADDR_CONTROL_STATUS: byte_v = {match_b_flag[ch], match_a_flag[ch], wrap_flag[ch],
            (ch == CH_EVEN) ? EVEN_BIT4_VALUE : odd_bit4_spare,
            out_b_sel[ch], out_a_sel[ch]};
        ADDR_CONST_A: byte_v = const_a_reg[ch];
        ADDR_CONST_B: byte_v = const_b_capture_reg[ch];
        ADDR_COUNT: byte_v = count_value[ch];
        default: byte_v = 8'h00;
      endcase
      if (!lane_en(bus_req_i, ch)) begin
        byte_v = 8'h00;
      end
      if (ch == CH_EVEN) begin
        next_rdata[15:8] = byte_v;
      end else begin
        next_rdata[7:0] = byte_v;
      end
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_rdata_o <= 16'h0000;
    end else if (bus_req_i.rd) begin
      bus_rdata_o <= next_rdata;
    end
  end

  // Request lines follow flag and enable, one cycle behind
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      even_match_a_irq_o <= 1'b0;
      even_match_b_irq_o <= 1'b0;
      odd_match_a_irq_o <= 1'b0;
      odd_match_b_irq_o <= 1'b0;
    end else begin
      even_match_a_irq_o <= match_a_flag[CH_EVEN] & timer_control[CH_EVEN].irq_en_a;
      even_match_b_irq_o <= match_b_flag[CH_EVEN] & timer_control[CH_EVEN].irq_en_b;
      odd_match_a_irq_o <= match_a_flag[CH_ODD] & timer_control[CH_ODD].irq_en_a;
      odd_match_b_irq_o <= match_b_flag[CH_ODD] & timer_control[CH_ODD].irq_en_b;
    end
  end

endmodule

// file: sim/ebtmc_timer_pair_props.sv
// Port-level assertions for the 8-bit timer channel pair
`timescale 1ns/1ps
module ebtmc_timer_pair_props (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire ebtmc_pkg::ebtmc_bus_req_t bus_req_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic timer_out_pin_oe_n_o,
  input wire logic timer_io_pin_oe_n_o,
  input wire logic even_match_a_irq_o,
  input wire logic even_match_b_irq_o
);
  import ebtmc_pkg::*;
  logic cap_mode;
  logic [3:0] even_sel;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // Shadow of the select bits, since the registers are not visible at the ports
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_mode <= 1'b0;
      even_sel <= 4'h0;
    end else if (bus_req_i.wr && bus_req_i.addr == ADDR_CONTROL_STATUS) begin
      if (bus_req_i.be_lo) cap_mode <= bus_req_i.wdata[BIT_CAPTURE_SEL];
      if (bus_req_i.be_hi) even_sel <= bus_req_i.wdata[11:8];
    end
  end

  property p_rdata_hold;
    !$past(bus_req_i.rd) |-> $stable(bus_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_unmapped;
    bus_req_i.rd && bus_req_i.addr > ADDR_COUNT |=> bus_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped word read not zero");
  property p_lane_off;
    bus_req_i.rd && !bus_req_i.be_hi |=> bus_rdata_o[15:8] == 8'h00;
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("disabled byte lane not zero");
  property p_cap_oe;
    cap_mode && $past(cap_mode) |-> timer_io_pin_oe_n_o && timer_out_pin_oe_n_o;
  endproperty
  a_cap_oe: assert property (p_cap_oe) else $error("pin driven in capture mode");
  property p_cap_even_b;
    cap_mode && $past(cap_mode, 2) |-> !$rose(even_match_b_irq_o);
  endproperty
  a_cap_even_b: assert property (p_cap_even_b) else $error("even match B in capture mode");
  property p_even_off;
    even_sel == 4'h0 && $past(even_sel) == 4'h0 |-> timer_out_pin_oe_n_o;
  endproperty
  a_even_off: assert property (p_even_off) else $error("even output on with no action");
  property p_irq_fall;
    $fell(even_match_a_irq_o) |-> $past(bus_req_i.wr) || $past(bus_req_i.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("match A request fell untouched");
  // Writing one to a set flag must leave it set two cycles on
  property p_flag_w1;
    bus_req_i.wr && !$past(bus_req_i.wr) && bus_req_i.addr == ADDR_CONTROL_STATUS &&
      bus_req_i.be_hi && bus_req_i.wdata[8 + BIT_MATCH_A] && even_match_a_irq_o
      |-> ##2 even_match_a_irq_o;
  endproperty
  a_flag_w1: assert property (p_flag_w1) else $error("writing one cleared match A");
endmodule

bind ebtmc_timer_pair ebtmc_timer_pair_props u_props (
  .clk_sys_i,
  .sys_rst_i,
  .bus_req_i,
  .bus_rdata_o,
  .timer_out_pin_oe_n_o,
  .timer_io_pin_oe_n_o,
  .even_match_a_irq_o,
  .even_match_b_irq_o
);

// file: sim/ebtmc_cpu_model.sv
// CPU model issuing requests on the timer pair's internal 16-bit bus
`timescale 1ns/1ps
module ebtmc_cpu_model (
  input wire logic clk_sys_i,
  output ebtmc_pkg::ebtmc_bus_req_t bus_req_o
);
  import ebtmc_pkg::*;
  initial bus_req_o = '0;

  // One request, held up to its taking edge, then released; leaves a gap cycle
  task automatic xfer(input logic w, input logic [2:0] a, input logic [1:0] be,
                      input logic [15:0] d);
    @(posedge clk_sys_i);
    #1;
    bus_req_o = '{addr: a, wr: w, rd: !w, be_hi: be[1], be_lo: be[0], wdata: d};
    @(posedge clk_sys_i);
    #1;
    bus_req_o.wr = 1'b0;
    bus_req_o.rd = 1'b0;
    // Released data and address show the inverse, so stale values never look valid
    bus_req_o.wdata = ~d;
    bus_req_o.addr = ~a;
  endtask
endmodule

// file: sim/tb.sv
// Self-checking bench: registers, compare outputs, capture and external counting
`timescale 1ns/1ps
module tb;
  import ebtmc_pkg::*;
  typedef struct packed {logic [2:0] a; logic [15:0] e; logic [15:0] m;} ebtmc_exp_t;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ext_clk_i = 1'b0;
  logic timer_io_pin_i = 1'b0;
  ebtmc_bus_req_t bus_req;
  logic [15:0] rdata;
  logic pin, pin_oe_n, io_oe_n, ea_irq, io_pin, oa_irq, ob_irq;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rs = 32'd92;
  logic rd_q = 1'b0;
  ebtmc_exp_t exp_q[$];
  logic [7:0] act_tab[6] = '{8'h02, 8'h01, 8'h03, 8'h03, 8'h09, 8'h0b};
  logic [15:0] rst_tab[6] = '{{2{RST_BYTE}}, {3'h0, EVEN_BIT4_VALUE, 4'h0, RST_BYTE},
    {2{RST_CONST}}, {2{RST_CONST}}, {2{RST_BYTE}}, 16'h0000};

  always #12.5 clk_sys_i = ~clk_sys_i;

  ebtmc_cpu_model cpu (.clk_sys_i, .bus_req_o(bus_req));
  ebtmc_timer_pair dut (.clk_sys_i, .sys_rst_i, .bus_req_i(bus_req), .bus_rdata_o(rdata),
    .ext_clk_i, .timer_out_pin_o(pin), .timer_out_pin_oe_n_o(pin_oe_n), .timer_io_pin_i,
    .timer_io_pin_o(io_pin), .timer_io_pin_oe_n_o(io_oe_n), .even_match_a_irq_o(ea_irq),
    .even_match_b_irq_o(), .odd_match_a_irq_o(oa_irq), .odd_match_b_irq_o(ob_irq));

  function automatic logic [15:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [2:0] a, input logic [1:0] be, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back('{a, e & m, m});
    cpu.xfer(1'b0, a, be, 16'h0000);
  endtask

  task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    cpu.xfer(1'b1, a, be, d);
  endtask

  task automatic end_of_test();
    // A read whose answer never came is a mismatch too
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("CHECK FAILED pending reads expected 0 seen %0d", exp_q.size());
    end
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read data lands on the taking edge of the strobe; the oldest note is compared one edge later
  always @(posedge clk_sys_i) begin
    if (rd_q && exp_q.size() > 0) begin
      ebtmc_exp_t x;
      x = exp_q.pop_front();
      chk($sformatf("register word %0d", x.a), x.e, rdata & x.m);
    end
    rd_q <= bus_req.rd;
  end

  // Whole run needs about nine thousand cycles; the slowest rate dominates
  initial begin
    #400000;
    error_cnt++;
    $display("Watchdog expired");
    end_of_test();
  end

  initial begin
    logic [15:0] w, w2;
    logic [7:0] old;
    logic [1:0] m;
    logic p, hit;
    int k;
    repeat (2) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    // Reset contents, an unmapped word and a single lane
    for (int i = 0; i < 6; i++) rd(i[2:0], 2'b11, rst_tab[i], 16'hffff);
    rd(ADDR_CONST_A, 2'b01, {8'h00, RST_CONST}, 16'hffff);
    w = xs();
    w2 = xs();
    wr(ADDR_CONST_A, 2'b11, w);
    wr(ADDR_CONST_A, 2'b01, w2);
    rd(ADDR_CONST_A, 2'b11, {w[15:8], w2[7:0]}, 16'hffff);
    // Even channel: match at 3, cleared on A, so a match every 32 cycles
    wr(ADDR_CONST_A, 2'b10, 16'h0300);
    wr(ADDR_CONST_B, 2'b10, 16'h0300);
    p = 1'b0;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CONTROL_STATUS, 2'b10, {act_tab[i], 8'h00});
      if (i == 0) wr(ADDR_CONTROL, 2'b10, {2'b11, 1'b0, CLR_ON_A, CKS_DIV8, 8'h00});
      k = 0;
      while (ea_irq !== 1'b1 && k < 100) begin
        @(posedge clk_sys_i);
        k++;
      end
      #1;
      m = act_tab[i][3:2] > act_tab[i][1:0] ? act_tab[i][3:2] : act_tab[i][1:0];
      case (m)
        ACT_TOGGLE: p = ~p;
        ACT_ONE: p = 1'b1;
        ACT_ZERO: p = 1'b0;
        default: p = p;
      endcase
      chk("timer out pin and enable", {15'h0, p}, {pin_oe_n, pin});
      rd(ADDR_COUNT, 2'b10, 16'h0000, 16'hff00);
      wr(ADDR_CONTROL_STATUS, 2'b10, {act_tab[i] | 8'he0, 8'h00});
      rd(ADDR_CONTROL_STATUS, 2'b10, 16'h4000, 16'h4000);
      wr(ADDR_CONTROL_STATUS, 2'b10, {act_tab[i], 8'h00});
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("match A request after clear", 16'h0000, {15'h0, ea_irq});
    end
    wr(ADDR_CONTROL_STATUS, 2'b10, 16'h0000);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("timer out enable off", 16'h0001, {15'h0, pin_oe_n});
    // Odd channel stopped, clears on capture; each edge code against both edges
    // Even channel keeps matching, so a leaked match B would raise its request
    wr(ADDR_CONTROL, 2'b01, {8'h00, 3'h4, CLR_ON_B, CKS_STOP});
    old = RST_CONST;
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_CONTROL_STATUS, 2'b01, {12'h001, c[1:0], 2'b00});
      for (int e = 0; e < 2; e++) begin
        w = xs();
        wr(ADDR_COUNT, 2'b01, w);
        timer_io_pin_i = ~timer_io_pin_i;
        repeat (6) @(posedge clk_sys_i);
        #1;
        hit = (c == 2) || (c == e);
        if (hit) old = w[7:0];
        rd(ADDR_CONST_B, 2'b01, {8'h00, old}, 16'h00ff);
        rd(ADDR_COUNT, 2'b01, {8'h00, hit ? 8'h00 : w[7:0]}, 16'h00ff);
      end
    end
    rd(ADDR_CONTROL_STATUS, 2'b01, 16'h0090, 16'h0090);
    chk("capture pin enable", 16'h0001, {15'h0, io_oe_n});
    chk("odd match B request", 16'h0001, {15'h0, ob_irq});
    wr(ADDR_CONTROL_STATUS, 2'b01, 16'h0000);
    // External clock: two pulses from fe, so every mode wraps
    for (int c = 5; c < 8; c++) begin
      wr(ADDR_COUNT, 2'b01, 16'h00fe);
      wr(ADDR_CONTROL, 2'b01, {13'h0000, c[2:0]});
      repeat (2) begin
        ext_clk_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        ext_clk_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1;
      end
      rd(ADDR_COUNT, 2'b01, {8'h00, 8'hfe + (c == 7 ? 8'h04 : 8'h02)}, 16'h00ff);
      wr(ADDR_CONTROL, 2'b01, 16'h0000);
      rd(ADDR_CONTROL_STATUS, 2'b01, 16'h0020, 16'h0020);
      wr(ADDR_CONTROL_STATUS, 2'b01, 16'h0000);
      rd(ADDR_CONTROL_STATUS, 2'b01, 16'h0000, 16'h0020);
    end
    // Prescaled rates: a window of whole periods holds an exact tick count
    for (int c = 2; c < 4; c++) begin
      wr(ADDR_CONTROL, 2'b01, {13'h0000, c[2:0]});
      wr(ADDR_COUNT, 2'b01, 16'h0000);
      repeat (c == 2 ? 127 : 8191) @(posedge clk_sys_i);
      rd(ADDR_COUNT, 2'b01, {8'h00, c == 2 ? 8'h02 : 8'h01}, 16'h00ff);
    end
    // Odd channel as a compare output: drive one on match A at 1
    wr(ADDR_CONST_A, 2'b01, 16'h0001);
    wr(ADDR_CONTROL_STATUS, 2'b01, 16'h0002);
    wr(ADDR_COUNT, 2'b01, 16'h0000);
    wr(ADDR_CONTROL, 2'b01, {8'h00, 3'h2, CLR_ON_A, CKS_DIV8});
    repeat (24) @(posedge clk_sys_i);
    #1;
    chk("timer io pin and enable", 16'h0001, {14'h0, io_oe_n, io_pin});
    chk("odd match A request", 16'h0001, {15'h0, oa_irq});
    repeat (3) @(posedge clk_sys_i);
    end_of_test();
  end
endmodule
